// ===== hdl/adcsc_pkg.sv
package adcsc_pkg;
    localparam logic [3:0] BYTE_DONE     = 4'h8;
    localparam int         REG_SEL_BIT   = 7;
    localparam int         REF_HI        = 6;
    localparam int         REF_LO        = 4;
    localparam int         CLK_BIT       = 3;
    localparam int         POL_BIT       = 2;
    localparam int         CFG_RST_BIT   = 1;
    localparam int         SCAN_HI       = 6;
    localparam int         SCAN_LO       = 5;
    localparam int         CHAN_HI       = 4;
    localparam int         CHAN_LO       = 1;
    localparam int         SGL_BIT       = 0;
    localparam int         ADDR_HI       = 7;
    localparam int         ADDR_LO       = 1;
    localparam int         RW_BIT        = 0;
    localparam int         HS_CODE_LO    = 3;
    localparam logic [4:0] HS_CODE_TOP   = 5'h01;
    localparam logic [2:0] REF_DEFAULT   = 3'h0;
    localparam logic       CLK_DEFAULT   = 1'b0;
    localparam logic       POL_DEFAULT   = 1'b0;
    localparam logic [1:0] SCAN_DEFAULT  = 2'h0;
    localparam logic [3:0] CHAN_DEFAULT  = 4'h0;
    localparam logic       SGL_DEFAULT   = 1'b1;
    localparam logic [6:0] ADDR_DEFAULT  = 7'h33;

    typedef enum logic [2:0] {
        ADCSC_IDLE     = 3'b000,
        ADCSC_ADDR     = 3'b001,
        ADCSC_ADDR_ACK = 3'b011,
        ADCSC_DATA     = 3'b010,
        ADCSC_DATA_ACK = 3'b110,
        ADCSC_SKIP     = 3'b100,
        ADCSC_HS_NACK  = 3'b101
    } adcsc_state_t;
endpackage

// ===== hdl/adcsc_sync_edge.sv
`timescale 1ns/100ps
module adcsc_sync_edge (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic stage1;
    logic stage2;
    logic stage3;

    // idle bus level is high, so reset to one to avoid a false edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise  = stage2 & ~stage3;
    assign fall  = ~stage2 & stage3;
endmodule

// ===== hdl/adcsc_top.sv
`timescale 1ns/100ps
// Summary of operation
// - acknowledge the address byte when it is complete and matches our address.
// - data byte with top bit one goes to setup, zero goes to configuration.
// - one or two data bytes in any order are all accepted.
// - acknowledge every data byte received during a write.
// - STOP returns bus timing from high-speed to fast/standard mode.
// - setup bits 6..4 select the reference, reset to 000.
// - configuration bits 6..5 select scan mode, reset to 00.
// - configuration bit 0 selects single-ended, resets to single-ended.
// - single-ended mode always yields unipolar results.
module adcsc_top
    import adcsc_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = ADDR_DEFAULT, // arbitrary value
    parameter int         CHAN_BITS  = 4
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    output logic [2:0] ref_select,
    output logic      ext_clock_select,
    output logic      polarity_select,
    output logic      bipolar_active,
    output logic [1:0] scan_select,
    output logic [3:0] chan_select,
    output logic      input_ended_select,
    output logic      hs_mode
);
    localparam logic [3:0] CHAN_MASK = 4'((1 << CHAN_BITS) - 1);

    logic         scl_level;
    logic         scl_rise;
    logic         scl_fall;
    logic         sda_level;
    logic         sda_rise;
    logic         sda_fall;
    logic         start_seen;
    logic         stop_seen;

    adcsc_state_t state;
    adcsc_state_t next_state;
    logic [3:0]   bit_count;
    logic [3:0]   next_bit_count;
    logic [7:0]   shift;
    logic [7:0]   next_shift;
    logic         read_req;
    logic         next_read_req;
    logic         next_sda_oe;
    logic         next_hs_mode;
    logic [2:0]   next_ref_select;
    logic         next_ext_clock_select;
    logic         next_polarity_select;
    logic         next_bipolar_active;
    logic [1:0]   next_scan_select;
    logic [3:0]   next_chan_select;
    logic         next_input_ended_select;
    logic         commit;

    adcsc_sync_edge u_scl (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (scl_in),
        .level   (scl_level),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    adcsc_sync_edge u_sda (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (sda_in),
        .level   (sda_level),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    // both lines pass equal sync depth, so their relative order is kept
    assign start_seen = sda_fall & scl_level;
    assign stop_seen  = sda_rise & scl_level;
    assign commit     = (state == ADCSC_DATA_ACK) & scl_fall;

    always_comb begin
        next_state              = state;
        next_bit_count          = bit_count;
        next_shift              = shift;
        next_read_req           = read_req;
        next_sda_oe             = sda_oe;
        next_hs_mode            = hs_mode;
        next_ref_select         = ref_select;
        next_ext_clock_select   = ext_clock_select;
        next_polarity_select    = polarity_select;
        next_scan_select        = scan_select;
        next_chan_select        = chan_select;
        next_input_ended_select = input_ended_select;
        if (start_seen) begin
            // a cut-short byte is dropped here, nothing is stored
            next_state     = ADCSC_ADDR;
            next_bit_count = 4'h0;
            next_sda_oe    = 1'b0;
        end else if (stop_seen) begin
            next_state  = ADCSC_IDLE;
            next_sda_oe = 1'b0;
            next_hs_mode = 1'b0;
        end else begin
            case (state)
                ADCSC_ADDR, ADCSC_DATA: begin
                    if (scl_rise && bit_count != BYTE_DONE) begin
                        next_shift     = {shift[6:0], sda_level};
                        next_bit_count = bit_count + 4'h1;
                    end else if (scl_fall && bit_count == BYTE_DONE) begin
                        if (state == ADCSC_DATA) begin
                            next_state  = ADCSC_DATA_ACK;
                            next_sda_oe = 1'b1;
                        end else if (shift[ADDR_HI:ADDR_LO] == SLAVE_ADDR) begin
                            next_state    = ADCSC_ADDR_ACK;
                            next_sda_oe   = 1'b1;
                            next_read_req = shift[RW_BIT];
                        end else if (shift[ADDR_HI:HS_CODE_LO] == HS_CODE_TOP) begin
                            next_state = ADCSC_HS_NACK;
                        end else begin
                            next_state = ADCSC_SKIP;
                        end
                    end
                end
                ADCSC_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe    = 1'b0;
                        next_bit_count = 4'h0;
                        // read cycles go to ADCSC_SKIP and are not served; only a write takes data
                        next_state     = read_req ? ADCSC_SKIP : ADCSC_DATA;
                    end
                end
                ADCSC_DATA_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe    = 1'b0;
                        next_bit_count = 4'h0;
                        next_state     = ADCSC_DATA;
                        if (shift[REG_SEL_BIT]) begin
                            next_ref_select       = shift[REF_HI:REF_LO];
                            next_ext_clock_select = shift[CLK_BIT];
                            next_polarity_select  = shift[POL_BIT];
                            if (!shift[CFG_RST_BIT]) begin
                                next_scan_select        = SCAN_DEFAULT;
                                next_chan_select        = CHAN_DEFAULT;
                                next_input_ended_select = SGL_DEFAULT;
                            end
                        end else begin
                            next_scan_select        = shift[SCAN_HI:SCAN_LO];
                            next_chan_select        = shift[CHAN_HI:CHAN_LO] & CHAN_MASK;
                            next_input_ended_select = shift[SGL_BIT];
                        end
                    end
                end
                ADCSC_HS_NACK: begin
                    // master code gets no acknowledge, high-speed timing follows
                    if (scl_fall) begin
                        next_hs_mode = 1'b1;
                        next_state   = ADCSC_SKIP;
                    end
                end
                ADCSC_IDLE, ADCSC_SKIP: begin
                    next_sda_oe = 1'b0;
                end
                default: begin
                    next_state  = ADCSC_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
        next_bipolar_active = next_polarity_select & ~next_input_ended_select;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state              <= ADCSC_IDLE;
            bit_count          <= 4'h0;
            shift              <= 8'h00;
            read_req           <= 1'b0;
            sda_out            <= 1'b0;
            sda_oe             <= 1'b0;
            hs_mode            <= 1'b0;
            ref_select         <= REF_DEFAULT;
            ext_clock_select   <= CLK_DEFAULT;
            polarity_select    <= POL_DEFAULT;
            bipolar_active     <= POL_DEFAULT;
            scan_select        <= SCAN_DEFAULT;
            chan_select        <= CHAN_DEFAULT;
            input_ended_select <= SGL_DEFAULT;
        end else begin
            state              <= next_state;
            bit_count          <= next_bit_count;
            shift              <= next_shift;
            read_req           <= next_read_req;
            sda_out            <= 1'b0;
            sda_oe             <= next_sda_oe;
            hs_mode            <= next_hs_mode;
            ref_select         <= next_ref_select;
            ext_clock_select   <= next_ext_clock_select;
            polarity_select    <= next_polarity_select;
            bipolar_active     <= next_bipolar_active;
            scan_select        <= next_scan_select;
            chan_select        <= next_chan_select;
            input_ended_select <= next_input_ended_select;
        end
    end

    // assertion helpers
    logic [2:0] shift_ref;
    logic [1:0] shift_scan;
    logic       shift_sgl;
    assign shift_ref  = shift[REF_HI:REF_LO];
    assign shift_scan = shift[SCAN_HI:SCAN_LO];
    assign shift_sgl  = shift[SGL_BIT];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_ack_states: assert property ($rose(sda_oe) |-> state inside {ADCSC_ADDR_ACK, ADCSC_DATA_ACK})
        else $error("acknowledge driven outside an acknowledge slot");
    chk_addr_match: assert property (state == ADCSC_ADDR_ACK |-> shift[ADDR_HI:ADDR_LO] == SLAVE_ADDR)
        else $error("address acknowledged without a match");
    chk_ack_release: assert property (
        state == ADCSC_DATA_ACK && scl_fall && !start_seen && !stop_seen |=> !sda_oe && state == ADCSC_DATA)
        else $error("data acknowledge not released after ninth clock");
    chk_stop_hs: assert property (stop_seen |=> !hs_mode && !sda_oe)
        else $error("stop did not leave high-speed mode");
    chk_setup_route: assert property (
        commit && shift[REG_SEL_BIT] && !start_seen && !stop_seen
        |=> ref_select == $past(shift_ref)
            && ext_clock_select == $past(shift[CLK_BIT]) && polarity_select == $past(shift[POL_BIT])
            && scan_select == ($past(shift[CFG_RST_BIT]) ? $past(scan_select) : SCAN_DEFAULT))
        else $error("setup byte routed wrongly");
    chk_cfg_route: assert property (
        commit && !shift[REG_SEL_BIT] && !start_seen && !stop_seen
        |=> scan_select == $past(shift_scan) && input_ended_select == $past(shift_sgl)
            && chan_select == ($past(shift[CHAN_HI:CHAN_LO]) & CHAN_MASK) && $stable(ref_select))
        else $error("configuration byte routed wrongly");
    chk_cfg_reset: assert property (
        commit && shift[REG_SEL_BIT] && !shift[CFG_RST_BIT] && !start_seen && !stop_seen
        |=> scan_select == SCAN_DEFAULT && chan_select == CHAN_DEFAULT && input_ended_select == SGL_DEFAULT)
        else $error("configuration not restored by setup reset bit");
    chk_single_unipolar: assert property (input_ended_select |-> !bipolar_active)
        else $error("bipolar coding active in single-ended mode");
    chk_chan_mask: assert property ((chan_select & ~CHAN_MASK) == 4'h0)
        else $error("unused channel bits not held at zero");
    chk_hold_regs: assert property (
        !commit |=> $stable(ref_select) && $stable(scan_select) && $stable(chan_select) && $stable(polarity_select))
        else $error("register changed without a completed byte");

    cov_setup_write: cover property (commit && shift[REG_SEL_BIT]);
    cov_cfg_write: cover property (commit && !shift[REG_SEL_BIT]);
    cov_two_bytes: cover property (commit ##[1:1000] commit);
    cov_hs_entry: cover property ($rose(hs_mode));
endmodule

// ===== testbench/adc_setup_config_write_test.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end
module adc_setup_config_write_test;
    import adcsc_pkg::*;
    localparam logic [6:0] DEV_ADDR = 7'h35; // arbitrary bus address
    logic        sys_clk;
    logic        nrst;
    logic        scl;
    logic        sda_pull;
    logic        sda_out;
    logic        sda_oe;
    logic        sda_line;
    logic [2:0]  ref_select;
    logic        ext_clock_select;
    logic        polarity_select;
    logic        bipolar_active;
    logic [1:0]  scan_select;
    logic [3:0]  chan_select;
    logic        input_ended_select;
    logic        hs_mode;
    int          err_total;
    int          checks;
    int          cycles;

    // open-drain wire with pull-up
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    adcsc_top #(.SLAVE_ADDR(DEV_ADDR), .CHAN_BITS(4)) adcsc_top_inst (
        .sys_clk            (sys_clk),
        .nrst               (nrst),
        .scl_in             (scl),
        .sda_in             (sda_line),
        .sda_out            (sda_out),
        .sda_oe             (sda_oe),
        .ref_select         (ref_select),
        .ext_clock_select   (ext_clock_select),
        .polarity_select    (polarity_select),
        .bipolar_active     (bipolar_active),
        .scan_select        (scan_select),
        .chan_select        (chan_select),
        .input_ended_select (input_ended_select),
        .hs_mode            (hs_mode)
    );

    adcsc_master_model adcsc_master_model_inst (
        .sys_clk  (sys_clk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_pull (sda_pull)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a run of about 3000 cycles; the ceiling leaves ample slack
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    function automatic logic [12:0] exp_regs(input logic [2:0] rs, input logic ck, input logic pl,
                                             input logic [1:0] sc, input logic [3:0] ch, input logic sg);
        return {rs, ck, pl, pl & ~sg, sc, ch, sg};
    endfunction

    task automatic check_regs(input logic [12:0] exp);
        `CHK("fields", exp, {ref_select, ext_clock_select, polarity_select, bipolar_active, scan_select, chan_select, input_ended_select});
    endtask

    task automatic xfer(input logic [7:0] data, input logic exp_ack);
        logic acked;
        adcsc_master_model_inst.send_byte(data, acked);
        `CHK("ack", exp_ack, acked);
    endtask

    initial begin
        nrst      = 1'b0;
        err_total = 0;
        checks    = 0;
        cycles    = 0;
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_regs(exp_regs(3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1));
        `CHK("hs idle", 1'b0, hs_mode);
        // foreign address: no ack and the following byte is ignored
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
        xfer(8'hde, 1'b0);
        adcsc_master_model_inst.stop_cond();
        check_regs(exp_regs(3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1));
        // setup then configuration
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1);
        xfer(8'hde, 1'b1);
        xfer(8'h56, 1'b1);
        adcsc_master_model_inst.stop_cond();
        check_regs(exp_regs(3'h5, 1'b1, 1'b1, 2'h2, 4'hb, 1'b0));
        // configuration then setup whose reset bit is low
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1);
        xfer(8'h27, 1'b1);
        xfer(8'h84, 1'b1);
        adcsc_master_model_inst.stop_cond();
        check_regs(exp_regs(3'h0, 1'b0, 1'b1, 2'h0, 4'h0, 1'b1));
        // configuration only, closed by repeated start, then setup only
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1);
        xfer(8'h1a, 1'b1);
        adcsc_master_model_inst.start_cond();
        check_regs(exp_regs(3'h0, 1'b0, 1'b1, 2'h0, 4'hd, 1'b0));
        xfer({DEV_ADDR, 1'b0}, 1'b1);
        xfer(8'hb2, 1'b1);
        adcsc_master_model_inst.stop_cond();
        check_regs(exp_regs(3'h3, 1'b0, 1'b0, 2'h0, 4'hd, 1'b0));
        // byte cut short by stop after four bits
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            adcsc_master_model_inst.send_bit(1'b0);
        end
        adcsc_master_model_inst.stop_cond();
        check_regs(exp_regs(3'h3, 1'b0, 1'b0, 2'h0, 4'hd, 1'b0));
        // read address is acknowledged but takes no data here
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR, 1'b1}, 1'b1);
        adcsc_master_model_inst.stop_cond();
        check_regs(exp_regs(3'h3, 1'b0, 1'b0, 2'h0, 4'hd, 1'b0));
        // high-speed master code is refused, repeated start keeps high-speed, stop drops it
        adcsc_master_model_inst.start_cond();
        xfer(8'h08, 1'b0);
        repeat (6) @(negedge sys_clk);
        `CHK("hs set", 1'b1, hs_mode);
        adcsc_master_model_inst.start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1);
        xfer(8'h5c, 1'b1);
        `CHK("hs kept", 1'b1, hs_mode);
        adcsc_master_model_inst.stop_cond();
        `CHK("hs clear", 1'b0, hs_mode);
        check_regs(exp_regs(3'h3, 1'b0, 1'b0, 2'h2, 4'he, 1'b0));
        wrap_up();
    end
endmodule

// ===== testbench/adcsc_master_model.sv
`timescale 1ns/100ps
module adcsc_master_model (
    input  wire logic sys_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    // the bus idles high and scl stands still between frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // also used as repeated start, so scl may be low on entry
    task automatic start_cond();
        wait_clk(2);
        sda_pull = 1'b0;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(8);
        sda_pull = 1'b1;
        wait_clk(8);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(2);
        sda_pull = 1'b1;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(8);
        sda_pull = 1'b0;
        wait_clk(8);
    endtask

    // data changes only while scl is low; one bit is 16 system cycles
    task automatic send_bit(input logic b);
        wait_clk(2);
        sda_pull = ~b;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(8);
        scl = 1'b0;
    endtask

    // msb first, then the ninth clock with sda released
    task automatic send_byte(input logic [7:0] data, output logic acked);
        for (int i = 7; i >= 0; i--) begin
            send_bit(data[i]);
        end
        wait_clk(2);
        sda_pull = 1'b0;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(4);
        acked = ~sda_line;
        wait_clk(4);
        scl = 1'b0;
    endtask
endmodule
